// file: logic/sdc_control.sv
/*
  Command/data control register and command-sequence launcher for a
  memory-card host controller, with Avalon-MM slave, interrupt status
  and FIFO request flags.
  Assumes: card_clk and card_busy are pins (synchronised here); the
  command engine and FIFOs run on mclk and drive the end strobes and
  FIFO word counts directly.
*/
// Implementation choices: the register addresses and the Avalon-MM register port.
// Behaviour
// - Completion-signal bit set by software, cleared by hardware at sequence end.
// - Ata read bit suppresses read-data timeout; hardware clears it afterwards.
// - Irq period bit: 1 gives exactly two cycles, 0 a longer period.
// - Auto-stop bit issues a stop command after data; cleared when stop completes.
// - Receive request when receive count at or above 8, 16 or 24.
// - Transmit request when transmit count below 8, 16 or 24.
// - Abort bit marks command as abort; hardware clears it on completion.
// - Bus width codes give one, four or eight lanes; 01 reserved.
// - DMA bit selects DMA and masks FIFO request interrupts.
// - Init bit sends 80 card clocks before the command.
// - Busy bit waits for card busy after no-data R1b command.
// - Stream bit selects stream mode, else block mode.
// - Write bit: 0 reads from card, 1 writes to card.
// - Data bit marks a data transfer and resets both FIFOs.
// - Response format code: none, R1/R1b, R2 up to R7.
`timescale 1ns/100ps
module sdc_control
  import sdc_pkg::*;
#(
  parameter int IRQ_LONG_CLKS = 8,
  parameter int LEVEL_W       = 6
) (
  input  wire logic                        mclk,
  input  wire logic                        reset,
  input  wire logic [sdc_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        card_clk,
  input  wire logic                        card_busy,
  input  wire logic                        cmd_end,
  input  wire logic                        data_end,
  input  wire logic                        stop_end,
  input  wire logic [LEVEL_W-1:0]          rx_level,
  input  wire logic [LEVEL_W-1:0]          tx_level,
  output logic                             cmd_issue,
  output logic                             stop_issue,
  output logic                             fifo_clear,
  output logic                             preamble_active,
  output logic      [sdc_pkg::RESP_W-1:0]  resp_format,
  output logic                             data_xfer,
  output logic                             write_dir,
  output logic                             stream_mode,
  output logic                             dma_mode,
  output logic      [7:0]                  lane_enable,
  output logic                             completion_signal_wait,
  output logic                             ata_read_access,
  output logic                             abort_cmd,
  output logic                             card_irq_window,
  output logic                             rx_drain_request,
  output logic                             tx_fill_request,
  output logic                             irq
);

  import sdc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0]        pins_s;
  logic              card_clk_s;
  logic              card_busy_s;
  logic              clk_d_ff;
  logic              nxt_clk_d;
  logic              card_edge;

  logic              wait_ff;
  logic              nxt_wait;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;
  logic              accept;
  logic              ctrl_wr;
  logic              launch_wr;
  logic              status_rd;
  logic              mask_wr;

  sdc_state_t        state_ff;
  sdc_state_t        nxt_state;
  logic [31:0]       ctrl_ff;
  logic [31:0]       nxt_ctrl;
  logic [31:0]       active_ff;
  logic [31:0]       nxt_active;
  logic [6:0]        pre_cnt_ff;
  logic [6:0]        nxt_pre_cnt;
  logic [7:0]        win_cnt_ff;
  logic [7:0]        nxt_win_cnt;
  logic              win_ff;
  logic              nxt_win;
  logic              cmd_issue_ff;
  logic              nxt_cmd_issue;
  logic              stop_issue_ff;
  logic              nxt_stop_issue;
  logic              fifo_clear_ff;
  logic              nxt_fifo_clear;
  logic              pre_ff;
  logic              nxt_pre;
  logic [7:0]        lane_ff;
  logic [7:0]        nxt_lane;
  logic              fin;
  logic              seq_done_ev;
  logic              stop_done_ev;

  logic              rx_req_ff;
  logic              nxt_rx_req;
  logic              tx_req_ff;
  logic              nxt_tx_req;
  logic [ST_W-1:0]   status_ff;
  logic [ST_W-1:0]   nxt_status;
  logic [ST_W-1:0]   mask_ff;
  logic [ST_W-1:0]   nxt_mask;
  logic              irq_ff;
  logic              nxt_irq;

  // Threshold code to word count; reserved code yields zero (no request)
  function automatic logic [6:0] thr_words(input logic [1:0] sel);
    case (sel)
      2'h0:    thr_words = THR_8;
      2'h1:    thr_words = THR_16;
      2'h2:    thr_words = THR_24;
      default: thr_words = 7'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and card clock edge detect
  // ----------------------------------------------------------------
  sdc_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   ({card_busy, card_clk}),
    .dout  (pins_s)
  );

  assign card_clk_s  = pins_s[0];
  assign card_busy_s = pins_s[1];
  assign nxt_clk_d   = card_clk_s;
  assign card_edge   = card_clk_s & ~clk_d_ff;

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, answer on the second
  // ----------------------------------------------------------------
  // The wait flop gives a fixed two-cycle access and keeps readdata a flop
  always_comb begin
    nxt_wait  = ~((avs_read | avs_write) & wait_ff);
    accept    = (avs_read | avs_write) & ~wait_ff;
    ctrl_wr   = accept & avs_write & (avs_address == OFS_CTRL);
    launch_wr = accept & avs_write & (avs_address == OFS_LAUNCH)
                & avs_writedata[BIT_LAUNCH];
    mask_wr   = accept & avs_write & (avs_address == OFS_MASK);
    status_rd = accept & avs_read & (avs_address == OFS_STATUS);
    nxt_rdata = rdata_ff;
    if (avs_read & wait_ff) begin
      case (avs_address)
        OFS_CTRL:   nxt_rdata = ctrl_ff;
        OFS_LAUNCH: nxt_rdata = {25'h0, state_ff, 3'h0, (state_ff != SDC_IDLE)};
        OFS_STATUS: nxt_rdata = {28'h0, status_ff};
        OFS_MASK:   nxt_rdata = {28'h0, mask_ff};
        default:    nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      clk_d_ff <= 1'b0;
    end else begin
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
      clk_d_ff <= nxt_clk_d;
    end
  end

  // ----------------------------------------------------------------
  // Control word and command sequencer
  // ----------------------------------------------------------------
  // Self-clearing bits are cleared first; a software write in the same
  // cycle then wins, so a fresh setting is never lost.
  always_comb begin
    nxt_state      = state_ff;
    nxt_ctrl       = ctrl_ff;
    nxt_active     = active_ff;
    nxt_pre_cnt    = pre_cnt_ff;
    nxt_win_cnt    = win_cnt_ff;
    nxt_cmd_issue  = 1'b0;
    nxt_stop_issue = 1'b0;
    nxt_fifo_clear = 1'b0;
    fin            = 1'b0;
    stop_done_ev   = 1'b0;
    if (card_edge && win_cnt_ff != 8'h00) begin
      nxt_win_cnt = win_cnt_ff - 8'h01;
    end
    case (state_ff)
      SDC_IDLE: begin
        if (launch_wr) begin
          nxt_active     = ctrl_ff;
          nxt_fifo_clear = ctrl_ff[BIT_DATA];
          nxt_pre_cnt    = 7'h00;
          if (ctrl_ff[BIT_INIT]) begin
            nxt_state = SDC_PRE;
          end else begin
            nxt_state     = SDC_CMD;
            nxt_cmd_issue = 1'b1;
          end
        end
      end
      SDC_PRE: begin
        if (card_edge) begin
          if (pre_cnt_ff == PREAMBLE_CLOCKS - 7'h01) begin
            nxt_state     = SDC_CMD;
            nxt_cmd_issue = 1'b1;
          end else begin
            nxt_pre_cnt = pre_cnt_ff + 7'h01;
          end
        end
      end
      SDC_CMD: begin
        if (cmd_end) begin
          nxt_ctrl[BIT_ABORT] = 1'b0;
          if (active_ff[BIT_DATA]) begin
            nxt_state = SDC_DATA;
          end else if (active_ff[BIT_BUSY]) begin
            nxt_state = SDC_BUSYW;
          end else begin
            fin = 1'b1;
          end
        end
      end
      SDC_BUSYW: begin
        if (!card_busy_s) begin
          fin = 1'b1;
        end
      end
      SDC_DATA: begin
        if (data_end) begin
          // Short window is exact; long one is a tunable count
          nxt_win_cnt = active_ff[BIT_IRQ_PERIOD] ? IRQ_SHORT_CLKS
                                                  : 8'(IRQ_LONG_CLKS);
          if (active_ff[BIT_AUTO_STOP]) begin
            nxt_state      = SDC_STOP;
            nxt_stop_issue = 1'b1;
          end else begin
            fin = 1'b1;
          end
        end
      end
      SDC_STOP: begin
        if (stop_end) begin
          nxt_ctrl[BIT_AUTO_STOP] = 1'b0;
          stop_done_ev            = 1'b1;
          fin                     = 1'b1;
        end
      end
      default: begin
        nxt_state = SDC_IDLE;
      end
    endcase
    if (fin) begin
      nxt_state                = SDC_IDLE;
      nxt_ctrl[BIT_COMPLETION] = 1'b0;
      nxt_ctrl[BIT_ATA_READ]   = 1'b0;
      nxt_active[BIT_ATA_READ] = 1'b0;
    end
    if (ctrl_wr) begin
      nxt_ctrl = avs_writedata & CTRL_WMASK;
    end
    seq_done_ev = fin;
    nxt_pre     = (nxt_state == SDC_PRE);
    nxt_win     = (nxt_win_cnt != 8'h00);
    case (nxt_active[BW_HI:BW_LO])
      BW_FOUR:  nxt_lane = LANES_4;
      BW_EIGHT: nxt_lane = LANES_8;
      default:  nxt_lane = LANES_1;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff      <= SDC_IDLE;
      ctrl_ff       <= CTRL_RST;
      active_ff     <= CTRL_RST;
      pre_cnt_ff    <= 7'h00;
      win_cnt_ff    <= 8'h00;
      win_ff        <= 1'b0;
      cmd_issue_ff  <= 1'b0;
      stop_issue_ff <= 1'b0;
      fifo_clear_ff <= 1'b0;
      pre_ff        <= 1'b0;
      lane_ff       <= LANES_1;
    end else begin
      state_ff      <= nxt_state;
      ctrl_ff       <= nxt_ctrl;
      active_ff     <= nxt_active;
      pre_cnt_ff    <= nxt_pre_cnt;
      win_cnt_ff    <= nxt_win_cnt;
      win_ff        <= nxt_win;
      cmd_issue_ff  <= nxt_cmd_issue;
      stop_issue_ff <= nxt_stop_issue;
      fifo_clear_ff <= nxt_fifo_clear;
      pre_ff        <= nxt_pre;
      lane_ff       <= nxt_lane;
    end
  end

  // ----------------------------------------------------------------
  // FIFO requests, sticky status and interrupt
  // ----------------------------------------------------------------
  // Reserved threshold codes hold the request low rather than guess
  always_comb begin
    nxt_rx_req = (ctrl_ff[RX_THR_HI:RX_THR_LO] != THR_RESERVED)
                 && (7'(rx_level) >= thr_words(ctrl_ff[RX_THR_HI:RX_THR_LO]));
    nxt_tx_req = (ctrl_ff[TX_THR_HI:TX_THR_LO] != THR_RESERVED)
                 && (7'(tx_level) < thr_words(ctrl_ff[TX_THR_HI:TX_THR_LO]));
    nxt_status = status_rd ? '0 : status_ff;
    nxt_status[ST_SEQ_DONE]  = nxt_status[ST_SEQ_DONE] | seq_done_ev;
    nxt_status[ST_STOP_DONE] = nxt_status[ST_STOP_DONE] | stop_done_ev;
    // DMA owns the FIFOs, so their request events stay silent
    nxt_status[ST_RX_REQ] = nxt_status[ST_RX_REQ] | (nxt_rx_req & ~rx_req_ff
                            & ~active_ff[BIT_DMA]);
    nxt_status[ST_TX_REQ] = nxt_status[ST_TX_REQ] | (nxt_tx_req & ~tx_req_ff
                            & ~active_ff[BIT_DMA]);
    nxt_mask = mask_wr ? avs_writedata[ST_W-1:0] : mask_ff;
    nxt_irq  = |(nxt_status & ~nxt_mask);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_req_ff <= 1'b0;
      tx_req_ff <= 1'b0;
      status_ff <= '0;
      mask_ff   <= MASK_RST;
      irq_ff    <= 1'b0;
    end else begin
      rx_req_ff <= nxt_rx_req;
      tx_req_ff <= nxt_tx_req;
      status_ff <= nxt_status;
      mask_ff   <= nxt_mask;
      irq_ff    <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------
  assign avs_readdata           = rdata_ff;
  assign avs_waitrequest        = wait_ff;
  assign cmd_issue              = cmd_issue_ff;
  assign stop_issue             = stop_issue_ff;
  assign fifo_clear             = fifo_clear_ff;
  assign preamble_active        = pre_ff;
  assign resp_format            = active_ff[RESP_HI:0];
  assign data_xfer              = active_ff[BIT_DATA];
  assign write_dir              = active_ff[BIT_WRITE];
  assign stream_mode            = active_ff[BIT_STREAM];
  assign dma_mode               = active_ff[BIT_DMA];
  assign lane_enable            = lane_ff;
  assign completion_signal_wait = active_ff[BIT_COMPLETION];
  assign ata_read_access        = active_ff[BIT_ATA_READ];
  assign abort_cmd              = active_ff[BIT_ABORT];
  assign card_irq_window        = win_ff;
  assign rx_drain_request       = rx_req_ff;
  assign tx_fill_request        = tx_req_ff;
  assign irq                    = irq_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Counts card edges while in preamble
  logic [7:0] chk_edges_ff;
  always_ff @(posedge mclk) begin
    if (reset || state_ff != SDC_PRE) begin
      chk_edges_ff <= 8'h00;
    end else if (card_edge) begin
      chk_edges_ff <= chk_edges_ff + 8'h01;
    end
  end

  chk_completion_clear: assert property (seq_done_ev && !ctrl_wr |=> !ctrl_ff[31])
    else $error("completion bit not cleared at sequence end");
  chk_ata_clear: assert property (fin && !ctrl_wr |=> !ctrl_ff[30] && !ata_read_access)
    else $error("ata read bit not cleared at sequence end");
  chk_irq_short: assert property (state_ff == SDC_DATA && data_end && active_ff[17]
    |=> win_cnt_ff == 8'h02 && card_irq_window)
    else $error("short irq window not loaded with two cycles");
  chk_stop_issue: assert property (state_ff == SDC_DATA && data_end && active_ff[16]
    |=> stop_issue && state_ff == SDC_STOP ##1 !stop_issue)
    else $error("auto stop not issued once");
  chk_rx_thresh: assert property (ctrl_ff[15:14] == 2'h1 && rx_level >= 16
    |=> rx_drain_request)
    else $error("receive request missing at sixteen words");
  chk_tx_thresh: assert property (ctrl_ff[13:12] == 2'h0 && tx_level >= 8
    |=> !tx_fill_request)
    else $error("transmit request high at eight words");
  chk_abort_clear: assert property (state_ff == SDC_CMD && cmd_end && !ctrl_wr
    |=> !ctrl_ff[11])
    else $error("abort bit not cleared after command");
  chk_lane_width: assert property (active_ff[10:9] == 2'h2 |-> lane_enable == 8'h0f)
    else $error("four-bit width without four lanes");
  chk_dma_mask: assert property (dma_mode && !status_ff[2] && !status_ff[3]
    && $stable(dma_mode) |=> !status_ff[2] && !status_ff[3])
    else $error("fifo request event raised in dma mode");
  chk_preamble_len: assert property (state_ff == SDC_PRE && nxt_state == SDC_CMD
    |-> chk_edges_ff == 8'h4f ##1 cmd_issue && !preamble_active)
    else $error("preamble did not last eighty card clocks");
  chk_busy_hold: assert property (state_ff == SDC_BUSYW && card_busy_s
    |-> !seq_done_ev ##1 state_ff == SDC_BUSYW)
    else $error("busy wait left while card busy");
  chk_fifo_clear: assert property (state_ff == SDC_IDLE && launch_wr && ctrl_ff[3]
    |=> fifo_clear && data_xfer ##1 !fifo_clear)
    else $error("fifo clear not pulsed at data launch");

  cov_preamble: cover property (state_ff == SDC_PRE ##1 state_ff == SDC_CMD);
  cov_auto_stop: cover property (stop_issue ##[1:200] stop_done_ev);
  cov_irq: cover property ($rose(irq));

endmodule

// file: logic/sdc_pkg.sv
/*
  Constants for the card command/data control block: register offsets,
  control-word field positions, reset values, status layout, sequencer
  states and the card-bus timing counts.
  Assumes a 32-bit register bus with byte addresses on aligned words.
*/
package sdc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          ADDR_W     = 5;
  localparam logic [4:0]  OFS_CTRL   = 5'h00;
  localparam logic [4:0]  OFS_LAUNCH = 5'h04;
  localparam logic [4:0]  OFS_STATUS = 5'h08;
  localparam logic [4:0]  OFS_MASK   = 5'h0c;

  // ----------------------------------------------------------------
  // Fields of command_data_control
  // ----------------------------------------------------------------
  localparam int BIT_COMPLETION = 31;
  localparam int BIT_ATA_READ   = 30;
  localparam int BIT_IRQ_PERIOD = 17;
  localparam int BIT_AUTO_STOP  = 16;
  localparam int RX_THR_HI      = 15;
  localparam int RX_THR_LO      = 14;
  localparam int TX_THR_HI      = 13;
  localparam int TX_THR_LO      = 12;
  localparam int BIT_ABORT      = 11;
  localparam int BW_HI          = 10;
  localparam int BW_LO          = 9;
  localparam int BIT_DMA        = 8;
  localparam int BIT_INIT       = 7;
  localparam int BIT_BUSY       = 6;
  localparam int BIT_STREAM     = 5;
  localparam int BIT_WRITE      = 4;
  localparam int BIT_DATA       = 3;
  localparam int RESP_HI        = 2;
  localparam int RESP_W         = 3;

  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'hc003_ffff;
  localparam int          BIT_LAUNCH = 0;

  // Bus width codes and lane enables
  localparam logic [1:0] BW_ONE   = 2'h0;
  localparam logic [1:0] BW_FOUR  = 2'h2;
  localparam logic [1:0] BW_EIGHT = 2'h3;
  localparam logic [7:0] LANES_1  = 8'h01;
  localparam logic [7:0] LANES_4  = 8'h0f;
  localparam logic [7:0] LANES_8  = 8'hff;

  // FIFO threshold codes; the last code is reserved
  localparam logic [1:0] THR_RESERVED = 2'h3;
  localparam logic [6:0] THR_8        = 7'h08;
  localparam logic [6:0] THR_16       = 7'h10;
  localparam logic [6:0] THR_24       = 7'h18;

  // ----------------------------------------------------------------
  // Status / mask layout
  // ----------------------------------------------------------------
  localparam int         ST_W         = 4;
  localparam int         ST_SEQ_DONE  = 0;
  localparam int         ST_STOP_DONE = 1;
  localparam int         ST_RX_REQ    = 2;
  localparam int         ST_TX_REQ    = 3;
  localparam logic [3:0] MASK_RST     = 4'hf;

  // ----------------------------------------------------------------
  // Card-bus timing counts (card clock cycles)
  // ----------------------------------------------------------------
  localparam logic [6:0] PREAMBLE_CLOCKS = 7'h50;
  localparam logic [7:0] IRQ_SHORT_CLKS  = 8'h02;

  typedef enum logic [2:0] {
    SDC_IDLE  = 3'b000,
    SDC_PRE   = 3'b001,
    SDC_CMD   = 3'b010,
    SDC_BUSYW = 3'b011,
    SDC_DATA  = 3'b100,
    SDC_STOP  = 3'b101
  } sdc_state_t;

endpackage

// file: logic/sdc_sync.sv
/*
  Two-stage synchroniser for a group of independent level signals.
  Assumes each bit is a level that stays put for several mclk periods.
*/
`timescale 1ns/100ps
module sdc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  // ----------------------------------------------------------------
  // Two flops per bit; only the second stage is ever read outside
  // ----------------------------------------------------------------
  always_comb begin
    nxt_meta = din;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign dout = sync_ff;

endmodule

// file: test/sdc_card_model.sv
/* Card-side model: card clock, busy level and engine end strobes.
   Assumes mclk from the bench and the issue pulses of the control block. */
`timescale 1ns/100ps
module sdc_card_model (
  input  wire logic mclk,
  input  wire logic run_clk,
  input  wire logic bsy,
  input  wire logic cmd_issue,
  input  wire logic stop_issue,
  input  wire logic data_xfer,
  output logic      card_clk,
  output logic      card_busy,
  output logic      cmd_end,
  output logic      data_end,
  output logic      stop_end
);
  logic [2:0] c = 3'h0, d = 3'h0, s = 3'h0;
  // Clock stands low between frames; odd phase so edges never meet mclk
  initial begin
    card_clk = 1'b0;
    #130;
    forever #400 card_clk = run_clk & ~card_clk;
  end
  // Ends trail each issue by a few cycles; busy level as commanded
  always @(posedge mclk) begin
    c <= {c[1:0], cmd_issue};
    d <= {d[1:0], c[2] & data_xfer};
    s <= {s[1:0], stop_issue};
    card_busy <= bsy;
  end
  assign cmd_end = c[2];
  assign data_end = d[2];
  assign stop_end = s[2];
endmodule

// file: test/tb_top.sv
/* Self-checking bench: Avalon tasks, card model and sequence tests.
   Assumes sdc_pkg and sdc_control from logic/. */
`timescale 1ns/100ps
module tb_top;
  import sdc_pkg::*;
  logic        mclk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic        run = 1'b0, bsy = 1'b0, avs_waitrequest, card_clk, card_busy, irq;
  logic        cmd_end, data_end, stop_end, cmd_issue, stop_issue, fifo_clear;
  logic        preamble_active, data_xfer, write_dir, stream_mode, dma_mode;
  logic        completion_signal_wait, ata_read_access, abort_cmd, card_irq_window;
  logic        rx_drain_request, tx_fill_request;
  logic [2:0]  resp_format;
  logic [4:0]  avs_address = 5'h00;
  logic [5:0]  rx_level = 6'h00, tx_level = 6'h3f;
  logic [7:0]  lane_enable, ln [4] = '{8'h01, 8'h01, 8'h0f, 8'hff};
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rv;
  int          miscompares = 0, cmp_count = 0, cyc = 0, nfc, nst, nw, np, t;
  sdc_control #(.IRQ_LONG_CLKS(4)) u_sdc_control (.*);
  sdc_card_model u_sdc_card_model (.run_clk(run | preamble_active), .*);
  always #50 mclk = ~mclk;
  // Pulse and window counters, plus the hang guard
  always @(posedge mclk) begin
    nfc += fifo_clear;
    nst += stop_issue;
    nw += card_irq_window;
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      results();
    end
  end
  always @(posedge card_clk) np += preamble_active;
  task automatic results();
    $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // Request held until waitrequest is sampled low; reads compare if named
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input string s);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    rv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
    if (s != "") chk(s, d, rv);
  endtask
  // Whole word first, then launch and poll until idle
  task automatic go(input logic [31:0] w);
    acc(1'b1, OFS_CTRL, w, "");
    acc(1'b1, OFS_LAUNCH, 32'h1, "");
    do acc(1'b0, OFS_LAUNCH, 32'h0, ""); while (rv[0] !== 1'b0);
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    acc(1'b0, OFS_CTRL, CTRL_RST, "ctrl");
    acc(1'b0, OFS_MASK, 32'hf, "mask");
    acc(1'b0, 5'h10, 32'h0, "unmapped");
    acc(1'b1, OFS_CTRL, 32'hffff_ffff, "");
    acc(1'b0, OFS_CTRL, CTRL_WMASK, "ctrl rw");
    $display("Test registers done");
    // Each threshold code, one level below and one at the threshold
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, OFS_CTRL, (i << 14) | (i << 12), "");
      for (int k = 7; k < 9; k++) begin
        rx_level <= 6'(8 * i + k);
        tx_level <= 6'(8 * i + k);
        repeat (2) @(posedge mclk);
        chk("rx req", k == 8 && i < 3, rx_drain_request);
        chk("tx req", k == 7 && i < 3, tx_fill_request);
      end
    end
    rx_level <= 6'h00;
    tx_level <= 6'h3f;
    $display("Test thresholds done");
    for (int i = 0; i < 8; i++) begin
      go(i | ((i & 3) << 4) | ((i & 4) << 6) | ((i & 3) << 9));
      chk("resp", i, resp_format);
      chk("lanes", ln[i & 3], lane_enable);
      chk("modes", i, {dma_mode, stream_mode, write_dir});
    end
    // DMA keeps the receive request but silences its status event
    acc(1'b0, OFS_STATUS, 32'h0, "");
    rx_level <= 6'h08;
    repeat (2) @(posedge mclk);
    acc(1'b0, OFS_STATUS, 32'h0, "dma mask");
    chk("rx dma", 1, rx_drain_request);
    rx_level <= 6'h00;
    $display("Test formats done");
    // Data runs with auto stop: short window first, then long
    acc(1'b0, OFS_STATUS, 32'h0, "");
    acc(1'b1, OFS_MASK, 32'h0, "");
    run <= 1'b1;
    for (int j = 1; j >= 0; j--) begin
      nfc = 0;
      nst = 0;
      nw = 0;
      go(32'hc001_0808 | (j << 17));
      chk("irq", 1, irq);
      repeat (60) @(posedge mclk);
      acc(1'b0, OFS_CTRL, 32'h8 | (j << 17), "ctrl");
      acc(1'b0, OFS_STATUS, 32'h3, "status");
      chk("fifo clr", 1, nfc);
      chk("stop", 1, nst);
      chk("ata abort", 1, {ata_read_access, abort_cmd});
      chk("latched", 3, {completion_signal_wait, data_xfer});
      if (j) t = nw;
      else chk("window", 1, nw > t + 8);
    end
    run <= 1'b0;
    np = 0;
    go(32'h80);
    chk("init clks", 80, np);
    bsy <= 1'b1;
    acc(1'b1, OFS_CTRL, 32'h41, "");
    acc(1'b1, OFS_LAUNCH, 32'h1, "");
    repeat (20) @(posedge mclk);
    acc(1'b0, OFS_LAUNCH, 32'h31, "busy wait");
    bsy <= 1'b0;
    go(32'h0);
    $display("Test sequences done");
    results();
  end
endmodule
